// >>> hdl/at_expiry_defs.vh
// Purpose: Shared constants of the transmit context and expiry check block.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only.
`ifndef AT_EXPIRY_DEFS_VH
`define AT_EXPIRY_DEFS_VH

// Register byte offsets.
`define OFF_REQ_PTR 8'h00
`define OFF_REQ_CTRL_SET 8'h04
`define OFF_REQ_CTRL_CLR 8'h08
`define OFF_RSP_PTR 8'h0c
`define OFF_RSP_CTRL_SET 8'h10
`define OFF_RSP_CTRL_CLR 8'h14
`define OFF_IRQ_STATUS 8'h18
`define OFF_IRQ_MASK 8'h1c
`define CTX_STRIDE 8'h0c

// Context control field positions.
`define CC_RUN 15
`define CC_WAKE 12
`define CC_DEAD 11
`define CC_ACTIVE 10
`define CC_EVT_HI 4
`define CC_EVT_LO 0
`define CC_RESET 16'h0000

// Program pointer layout.
`define PTR_ZC_HI 3
`define PTR_ZC_LO 0
`define PTR_BASE_LO 4
`define PTR_RESET 32'h00000000
`define ZC_LAST 4'h0
`define ZC_MIN 4'h2
`define ZC_MAX 4'h8

// Expiry stamp layout.
`define STAMP_SEC_HI 15
`define STAMP_SEC_LO 13
`define STAMP_CYC_HI 12
`define STAMP_CYC_LO 0

// Interrupt status bits.
`define IRQ_REQ_DONE 0
`define IRQ_RSP_DONE 1
`define IRQ_TIMEOUT 2
`define IRQ_DEAD 3
`define IRQ_BITS 4
`define IRQ_RESET 4'h0

`endif

// >>> hdl/expiry_compare.v
// Purpose: Registered verdict of a response expiry stamp against the live cycle timer.
// Assumes: Timer inputs are synchronous to pclk; cycle number stays below 8000.
// Notes: Verdict appears one cycle after the request.
`timescale 1ns/100ps
`include "at_expiry_defs.vh"

module expiry_compare (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Request.
    input wire check_req,
    input wire [15:0] expiry_stamp,
    input wire [2:0] second_count_low,
    input wire [12:0] cycle_number,
    // Verdict.
    output reg verdict_valid,
    output reg verdict_send
);

    wire [2:0] sec_diff;
    wire [13:0] cyc_diff;
    reg next_send;

    // (RL3) Wrapping seconds subtraction.
    assign sec_diff = expiry_stamp[`STAMP_SEC_HI:`STAMP_SEC_LO] - second_count_low;
    // (RL6) Zero-extended 14-bit cycle subtraction, top bit is the sign.
    assign cyc_diff = {1'b0, expiry_stamp[`STAMP_CYC_HI:`STAMP_CYC_LO]} - {1'b0, cycle_number};

    // (RL1) Stamp is seconds plus cycle number.
    always @* begin
        next_send = 1'b0;
        if (sec_diff[2]) begin
            // (RL4) Late second, refuse.
            next_send = 1'b0;
        end else if (sec_diff[1:0] != 2'b00) begin
            // (RL5) Distant future, allow.
            next_send = 1'b1;
        end else begin
            // (RL7) Sign decides send.
            next_send = ~cyc_diff[13];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verdict_valid <= 1'b0;
            verdict_send <= 1'b0;
        end else begin
            verdict_valid <= check_req;
            verdict_send <= check_req & next_send;
        end
    end

endmodule

// >>> hdl/ctx_pointer.v
// Purpose: One context program pointer register with block count decode.
// Assumes: Writes come as single-cycle strobes.
// Notes: The low nibble is the block count, the rest the descriptor base.
`timescale 1ns/100ps
`include "at_expiry_defs.vh"

module ctx_pointer (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Write port.
    input wire ptr_write,
    input wire [31:0] ptr_wdata,
    // Decoded pointer.
    output reg [31:0] ptr_value,
    output wire [31:0] descriptor_base,
    output wire [3:0] block_count,
    output wire count_reserved
);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_value <= `PTR_RESET;
        end else if (ptr_write) begin
            ptr_value <= ptr_wdata;
        end
    end

    // (RL13) Base has zero low nibble.
    assign descriptor_base = {ptr_value[31:`PTR_BASE_LO], 4'h0};
    // (RL14) Low nibble is block count.
    assign block_count = ptr_value[`PTR_ZC_HI:`PTR_ZC_LO];
    // (RL16) Only zero and two to eight are legal.
    assign count_reserved = (block_count != `ZC_LAST) &&
                            ((block_count < `ZC_MIN) || (block_count > `ZC_MAX));

endmodule

// >>> hdl/async_tx_response_expiry_check.v
// Purpose: Two transmit contexts with pointer and control registers, plus the response expiry gate.
// Assumes: The fetch engine raises check_req before each response load attempt.
// Notes: APB slave, no wait state, interrupt output is a level.
//
// Function
// (RL1) Stamp holds 3-bit seconds, 13-bit cycles.
// (RL2) Check stamp before each load or retry.
// (RL3) Subtract timer seconds with 3-bit wrap.
// (RL4) Top difference bit set means late, refuse.
// (RL5) Other nonzero difference means future, send.
// (RL6) Same second: signed 14-bit cycle subtraction.
// (RL7) Negative cycles reject with timeout event.
// (RL8) Software puts stamp in first descriptor.
// (RL9) No recheck while packet partly loaded.
// (RL10) Software shortens stamp by FIFO delay.
// (RL11) Each context has pointer and control.
// (RL12) Start fetch at pointer when run.
// (RL13) Descriptors sit on 16-byte boundaries.
// (RL14) Pointer low nibble is block count.
// (RL15) Control written by software, updated by hardware.
// (RL16) Count 0 last, 2-8 packet, rest reserved.
// (RL17) Completion code lands in event field.
`timescale 1ns/100ps
`include "at_expiry_defs.vh"

module async_tx_response_expiry_check #(
    parameter [4:0] EVT_TIMEOUT = 5'h0a,
    parameter N_CTX = 2
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Live cycle timer.
    input wire [2:0] second_count_low,
    input wire [12:0] cycle_number,
    // Descriptor fetch engine, one bit or slice per context, request context first.
    output wire [N_CTX-1:0] ctx_start,
    output wire [32*N_CTX-1:0] start_base,
    output wire [4*N_CTX-1:0] start_count,
    output wire [N_CTX-1:0] ctx_wake,
    input wire [N_CTX-1:0] ctx_done,
    input wire [N_CTX-1:0] done_last,
    input wire [5*N_CTX-1:0] done_code,
    // Response load gate.
    input wire check_req,
    input wire check_retry,
    input wire [15:0] expiry_stamp,
    input wire pkt_loaded,
    output reg check_pass,
    output reg check_reject,
    // Interrupt.
    output reg irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    wire setup = psel & ~penable & ~pready;
    wire wr_now = psel & penable & pready & pwrite;
    reg [31:0] next_prdata;
    reg next_err;
    reg [`IRQ_BITS-1:0] irq_status;
    reg [`IRQ_BITS-1:0] irq_mask;
    wire [32*N_CTX-1:0] ptr_flat;
    wire [16*N_CTX-1:0] ctrl_flat;
    wire [N_CTX-1:0] dead_event;
    wire [N_CTX-1:0] done_event;
    wire verdict_valid;
    wire verdict_send;
    reg checked;
    reg bypass_d;
    reg reject_now;

    always @* begin
        next_prdata = 32'h00000000;
        next_err = 1'b0;
        case (paddr)
            `OFF_REQ_PTR: next_prdata = ptr_flat[31:0];
            `OFF_REQ_CTRL_SET: next_prdata = {16'h0000, ctrl_flat[15:0]};
            `OFF_REQ_CTRL_CLR: next_prdata = {16'h0000, ctrl_flat[15:0]};
            `OFF_RSP_PTR: next_prdata = ptr_flat[63:32];
            `OFF_RSP_CTRL_SET: next_prdata = {16'h0000, ctrl_flat[31:16]};
            `OFF_RSP_CTRL_CLR: next_prdata = {16'h0000, ctrl_flat[31:16]};
            `OFF_IRQ_STATUS: next_prdata = {28'h0000000, irq_status};
            `OFF_IRQ_MASK: next_prdata = {28'h0000000, irq_mask};
            default: next_err = 1'b1;
        endcase
    end

    // Ready is raised for the first access cycle only, so no transfer takes a wait state.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            if (setup) begin
                pslverr <= next_err;
                prdata <= pwrite ? 32'h00000000 : next_prdata;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-context registers.

    genvar g;
    generate
        for (g = 0; g < N_CTX; g = g + 1) begin : ctx
            localparam integer CTX_OFF = `CTX_STRIDE * g;
            wire [7:0] off_ptr = CTX_OFF[7:0] + `OFF_REQ_PTR;
            wire [7:0] off_set = CTX_OFF[7:0] + `OFF_REQ_CTRL_SET;
            wire [7:0] off_clr = CTX_OFF[7:0] + `OFF_REQ_CTRL_CLR;
            wire wr_set = wr_now && (paddr == off_set);
            wire wr_clr = wr_now && (paddr == off_clr);
            wire [31:0] base;
            wire [3:0] count;
            wire reserved;
            reg run;
            reg run_d;
            reg wake;
            reg dead;
            reg active;
            reg [4:0] evt;
            reg start;
            reg wake_out;
            reg [31:0] sbase;
            reg [3:0] scount;
            reg dead_pulse;
            wire reject_here = (g == 1) && reject_now;

            // (RL11) Own pointer per context.
            ctx_pointer u_ptr (
                .pclk(pclk),
                .presetn(presetn),
                .ptr_write(wr_now && (paddr == off_ptr)),
                .ptr_wdata(pwdata),
                .ptr_value(ptr_flat[32*g+31:32*g]),
                .descriptor_base(base),
                .block_count(count),
                .count_reserved(reserved)
            );

            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    run <= 1'b0;
                    run_d <= 1'b0;
                    wake <= 1'b0;
                    dead <= 1'b0;
                    active <= 1'b0;
                    evt <= 5'h00;
                    start <= 1'b0;
                    wake_out <= 1'b0;
                    sbase <= 32'h00000000;
                    scount <= 4'h0;
                    dead_pulse <= 1'b0;
                end else begin
                    start <= 1'b0;
                    dead_pulse <= 1'b0;
                    wake_out <= wake & active;
                    run_d <= run;
                    // (RL15) Software sets and clears run; software sets wake, hardware clears it.
                    if (wr_set && pwdata[`CC_RUN]) begin
                        run <= 1'b1;
                    end else if (wr_clr && pwdata[`CC_RUN]) begin
                        run <= 1'b0;
                    end
                    if (wr_set && pwdata[`CC_WAKE]) begin
                        wake <= 1'b1;
                    end else if (wake & active) begin
                        wake <= 1'b0;
                    end
                    // (RL12) Start fetch at pointer.
                    if (run && !run_d && !dead) begin
                        // (RL16) Reserved count kills context.
                        if (reserved) begin
                            dead <= 1'b1;
                            dead_pulse <= 1'b1;
                        end else if (count != `ZC_LAST) begin
                            active <= 1'b1;
                            start <= 1'b1;
                            sbase <= base;
                            scount <= count;
                        end
                    end else if (!run || (ctx_done[g] && done_last[g])) begin
                        active <= 1'b0;
                    end
                    if (!run && run_d) begin
                        dead <= 1'b0;
                    end
                    // (RL17) Completion code into event field.
                    if (reject_here) begin
                        evt <= EVT_TIMEOUT;
                    end else if (ctx_done[g]) begin
                        evt <= done_code[5*g+4:5*g];
                    end
                end
            end

            assign ctrl_flat[16*g+15:16*g] = {run, 2'b00, wake, dead, active, 5'h00, evt};
            assign ctx_start[g] = start;
            assign ctx_wake[g] = wake_out;
            assign start_base[32*g+31:32*g] = sbase;
            assign start_count[4*g+3:4*g] = scount;
            assign dead_event[g] = dead_pulse;
            assign done_event[g] = ctx_done[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Response expiry gate.

    // (RL2) Fresh compare on first try and retry.
    wire compare_req = check_req && (check_retry || !checked);

    expiry_compare u_cmp (
        .pclk(pclk),
        .presetn(presetn),
        .check_req(compare_req),
        .expiry_stamp(expiry_stamp),
        .second_count_low(second_count_low),
        .cycle_number(cycle_number),
        .verdict_valid(verdict_valid),
        .verdict_send(verdict_send)
    );

    always @* begin
        reject_now = verdict_valid & ~verdict_send;
    end

    // A passed packet keeps its pass until it is fully in the FIFO or retried.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checked <= 1'b0;
            bypass_d <= 1'b0;
            check_pass <= 1'b0;
            check_reject <= 1'b0;
        end else begin
            // (RL9) Skip recheck during partial load.
            bypass_d <= check_req && !check_retry && checked;
            check_pass <= (verdict_valid & verdict_send) | bypass_d;
            check_reject <= reject_now;
            if (verdict_valid && verdict_send) begin
                checked <= 1'b1;
            end else if (pkt_loaded || (check_req && check_retry) || reject_now) begin
                checked <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts.

    wire [`IRQ_BITS-1:0] irq_set = {|dead_event, reject_now, done_event[1], done_event[0]};
    wire wr_status = wr_now && (paddr == `OFF_IRQ_STATUS);

    // A new event wins over a write-one-to-clear in the same cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= `IRQ_RESET;
            irq_mask <= `IRQ_RESET;
            irq <= 1'b0;
        end else begin
            irq_status <= irq_set | (irq_status & ~(wr_status ? pwdata[`IRQ_BITS-1:0] : `IRQ_RESET));
            if (wr_now && (paddr == `OFF_IRQ_MASK)) begin
                irq_mask <= pwdata[`IRQ_BITS-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

endmodule

// >>> testbench/expiry_check_props.sv
// Purpose: Assertions on the expiry gate, the start outputs and the APB answer.
// Assumes: Check requests come at least three cycles apart.
// Notes: The held flag mirrors the pass that the gate remembers.
`timescale 1ns/100ps
module expiry_check_props #(
    parameter [4:0] EVT_TIMEOUT = 5'h0a,
    parameter N_CTX = 2
) (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // APB answer.
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // Timer and gate.
    input wire [2:0] second_count_low,
    input wire [12:0] cycle_number,
    input wire check_req,
    input wire check_retry,
    input wire [15:0] expiry_stamp,
    input wire pkt_loaded,
    input wire check_pass,
    input wire check_reject,
    // Context start.
    input wire [N_CTX-1:0] ctx_start,
    input wire [32*N_CTX-1:0] start_base,
    input wire [4*N_CTX-1:0] start_count
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [2:0] sdiff = expiry_stamp[15:13] - second_count_low;
    wire [13:0] cdiff = {1'b0, expiry_stamp[12:0]} - {1'b0, cycle_number};
    reg held;
    wire fresh = check_req && (check_retry || !held);
    ////////////////////////////////////////
    // A pass is only remembered until the packet is loaded or a retry asks again.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held <= 1'b0;
        end else if (pkt_loaded || check_reject || (check_req && check_retry)) begin
            held <= 1'b0;
        end else if (check_pass) begin
            held <= 1'b1;
        end
    end
    property p_verdict; check_req |-> ##2 (check_pass ^ check_reject); endproperty
    a_verdict: assert property (p_verdict) else $error("verdict missing two cycles after request");
    property p_late; fresh && sdiff[2] |-> ##2 check_reject; endproperty
    a_late: assert property (p_late) else $error("late stamp not rejected");
    property p_future; fresh && !sdiff[2] && sdiff[1:0] != 2'b00 |-> ##2 check_pass; endproperty
    a_future: assert property (p_future) else $error("future stamp not sent");
    property p_same; fresh && sdiff == 3'b000 |-> ##2 (check_reject == cdiff[13]); endproperty
    a_same: assert property (p_same) else $error("cycle compare wrong");
    property p_held; check_req && !check_retry && held && !pkt_loaded |-> ##2 check_pass; endproperty
    a_held: assert property (p_held) else $error("stamp checked again");
    property p_start0;
        ctx_start[0] |-> start_base[3:0] == 4'h0 && start_count[3:0] >= 4'h2 && start_count[3:0] <= 4'h8
            ##1 !ctx_start[0];
    endproperty
    a_start0: assert property (p_start0) else $error("bad start shape");
    property p_hold1; ctx_start[1] |=> $stable(start_base[63:32]) [*3]; endproperty
    a_hold1: assert property (p_hold1) else $error("start base moved");
    property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
    a_ready: assert property (p_ready) else $error("pready not one cycle after setup");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("pslverr without pready");
    c_reject: cover property (check_reject);
    c_pass: cover property (check_pass);
    c_start: cover property (ctx_start[1]);
    c_err: cover property (pslverr);
endmodule
bind async_tx_response_expiry_check expiry_check_props #(.EVT_TIMEOUT(EVT_TIMEOUT), .N_CTX(N_CTX)) i_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .second_count_low(second_count_low), .cycle_number(cycle_number), .check_req(check_req),
    .check_retry(check_retry), .expiry_stamp(expiry_stamp), .pkt_loaded(pkt_loaded), .check_pass(check_pass),
    .check_reject(check_reject), .ctx_start(ctx_start), .start_base(start_base), .start_count(start_count));

// >>> testbench/link_side_model.sv
// Purpose: Far side that takes each started packet and reports its completion.
// Assumes: Every packet is the last of its program.
// Notes: delay sets a prompt or a slow answer.
`timescale 1ns/100ps
module link_side_model (
    // Clock and reset.
    input wire pclk,
    input wire presetn,
    // Pace and answer.
    input wire [3:0] delay,
    input wire [4:0] ack_code,
    // Context handshake.
    input wire [1:0] ctx_start,
    output reg [1:0] ctx_done,
    output wire [1:0] done_last,
    output wire [9:0] done_code
);
    reg [3:0] wait_cnt [0:1];
    reg [1:0] busy;
    integer k;
    ////////////////////////////////////////
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 2'b00;
            ctx_done <= 2'b00;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                ctx_done[k] <= busy[k] && wait_cnt[k] == 4'h0;
                if (ctx_start[k]) begin
                    busy[k] <= 1'b1;
                    wait_cnt[k] <= delay;
                end else if (busy[k] && wait_cnt[k] == 4'h0) begin
                    busy[k] <= 1'b0;
                end else if (busy[k]) begin
                    wait_cnt[k] <= wait_cnt[k] - 4'h1;
                end
            end
        end
    end
    // completion code handed back
    // Outside a completion the code lines show the inverse, so a stale sample cannot match.
    assign done_last = ctx_done;
    assign done_code = ctx_done != 2'b00 ? {2{ack_code}} : ~{2{ack_code}};
endmodule

// >>> testbench/async_tx_response_expiry_check_tb.sv
// Purpose: Self-checking bench for the transmit contexts and the expiry gate.
// Assumes: The link model answers every start with a final completion.
// Notes: Registers are reached only through the APB task.
`timescale 1ns/100ps
`include "at_expiry_defs.vh"
module async_tx_response_expiry_check_tb;
    reg pclk, presetn, psel, penable, pwrite, check_req, check_retry, pkt_loaded, err;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd, seen_base;
    reg [2:0] second_count_low;
    reg [12:0] cycle_number;
    reg [15:0] expiry_stamp;
    reg [3:0] link_delay, seen_count;
    wire [31:0] prdata;
    wire pready, pslverr, check_pass, check_reject, irq;
    wire [1:0] ctx_start, ctx_done, done_last, ctx_wake;
    wire [63:0] start_base;
    wire [7:0] start_count;
    wire [9:0] done_code;
    integer n_errors, samples_checked, starts0, wakes1, n, i;
    async_tx_response_expiry_check i_async_tx_response_expiry_check (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .second_count_low(second_count_low), .cycle_number(cycle_number), .ctx_start(ctx_start),
        .start_base(start_base), .start_count(start_count), .ctx_wake(ctx_wake), .ctx_done(ctx_done),
        .done_last(done_last), .done_code(done_code), .check_req(check_req), .check_retry(check_retry),
        .expiry_stamp(expiry_stamp), .pkt_loaded(pkt_loaded), .check_pass(check_pass),
        .check_reject(check_reject), .irq(irq));
    link_side_model i_link_side_model (.pclk(pclk), .presetn(presetn), .delay(link_delay), .ack_code(5'h11),
        .ctx_start(ctx_start), .ctx_done(ctx_done), .done_last(done_last), .done_code(done_code));
    always @(posedge pclk) begin
        if (ctx_start[0] === 1'b1) begin
            starts0 = starts0 + 1;
        end
        if (ctx_wake[1] === 1'b1) begin
            wakes1 = wakes1 + 1;
        end
        if (ctx_start[1] === 1'b1) begin
            seen_base = start_base[63:32];
            seen_count = start_count[7:4];
        end
    end
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ////////////////////////////////////////
    task test_done;
        begin
            $display("checks %0d errors %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    task chk(input [8*12:1] what, input [31:0] exp, input [31:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    // The first edge wait keeps a release and the next request out of one time step.
    task apb(input wr, input [7:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && t < 20) begin
                t = t + 1;
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                n_errors = n_errors + 1;
                test_done;
            end
        end
    endtask
    task rchk(input [7:0] a, input [31:0] exp, input [8*12:1] what);
        begin
            apb(1'b0, a, 32'h0);
            chk(what, exp, rd);
        end
    endtask
    task gate(input retry, input [15:0] st, input [2:0] s, input [12:0] c, input ok);
        begin
            @(posedge pclk);
            second_count_low <= s;
            cycle_number <= c;
            expiry_stamp <= st;
            check_retry <= retry;
            check_req <= 1'b1;
            @(posedge pclk);
            check_req <= 1'b0;
            @(posedge pclk);
            #1;
            chk("pass", ok, check_pass);
            chk("reject", !ok, check_reject);
        end
    endtask
    initial begin
        {presetn, psel, penable, pwrite, check_req, check_retry, pkt_loaded} = 7'h00;
        {paddr, pwdata, second_count_low, cycle_number, expiry_stamp} = 72'h0;
        link_delay = 4'hf;
        n_errors = 0;
        samples_checked = 0;
        starts0 = 0;
        wakes1 = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rchk(`OFF_REQ_PTR, 32'h0, "req ptr");
        rchk(`OFF_RSP_CTRL_SET, 32'h0, "rsp ctrl");
        apb(1'b0, 8'h20, 32'h0);
        chk("slverr", 32'h1, err);
        gate(1'b1, {3'h0, 13'h0fa0}, 3'h0, 13'h0f9e, 1'b1);
        gate(1'b1, {3'h0, 13'h0fa0}, 3'h0, 13'h0fa0, 1'b1);
        gate(1'b1, {3'h0, 13'h0fa0}, 3'h0, 13'h0fa1, 1'b0);
        gate(1'b1, {3'h0, 13'h1000}, 3'h0, 13'h1001, 1'b0);
        gate(1'b1, {3'h0, 13'h0000}, 3'h0, 13'h1f3f, 1'b0);
        gate(1'b1, {3'h0, 13'h0000}, 3'h1, 13'h0000, 1'b0);
        gate(1'b1, {3'h3, 13'h0000}, 3'h0, 13'h1f3f, 1'b1);
        gate(1'b1, {3'h0, 13'h0000}, 3'h7, 13'h1f3f, 1'b1);
        gate(1'b1, {3'h0, 13'h0100}, 3'h0, 13'h0050, 1'b1);
        gate(1'b0, {3'h0, 13'h0100}, 3'h0, 13'h0200, 1'b1);
        gate(1'b1, {3'h0, 13'h0100}, 3'h0, 13'h0200, 1'b0);
        gate(1'b1, {3'h0, 13'h0100}, 3'h0, 13'h0050, 1'b1);
        @(posedge pclk);
        pkt_loaded <= 1'b1;
        @(posedge pclk);
        pkt_loaded <= 1'b0;
        gate(1'b0, {3'h4, 13'h0100}, 3'h0, 13'h0050, 1'b0);
        rchk(`OFF_RSP_CTRL_CLR, 32'h0000_000a, "rsp event");
        apb(1'b1, `OFF_RSP_PTR, 32'h0000_2008);
        rchk(`OFF_RSP_PTR, 32'h0000_2008, "rsp ptr");
        apb(1'b1, `OFF_RSP_CTRL_SET, 32'h0000_8000);
        repeat (3) @(posedge pclk);
        chk("base", 32'h2000, seen_base);
        chk("count", 32'h8, seen_count);
        rchk(`OFF_RSP_CTRL_SET, 32'h0000_840a, "rsp active");
        apb(1'b1, `OFF_RSP_CTRL_SET, 32'h0000_1000);
        repeat (20) @(posedge pclk);
        chk("wake", 32'h1, wakes1);
        rchk(`OFF_RSP_CTRL_SET, 32'h0000_8011, "rsp done");
        link_delay <= 4'h0;
        for (i = 0; i < 16; i = i + 1) begin
            apb(1'b1, `OFF_REQ_PTR, {28'h0000400, i[3:0]});
            n = starts0;
            apb(1'b1, `OFF_REQ_CTRL_SET, 32'h0000_8000);
            repeat (3) @(posedge pclk);
            apb(1'b0, `OFF_REQ_CTRL_SET, 32'h0);
            chk("dead", i == 1 || i > 8, rd[11]);
            chk("starts", i >= 2 && i <= 8, starts0 - n);
            apb(1'b1, `OFF_REQ_CTRL_CLR, 32'h0000_8000);
        end
        rchk(`OFF_IRQ_STATUS, 32'hf, "status");
        chk("irq masked", 32'h0, irq);
        apb(1'b1, `OFF_IRQ_MASK, 32'h8);
        @(posedge pclk);
        #1;
        chk("irq on", 32'h1, irq);
        apb(1'b1, `OFF_IRQ_STATUS, 32'h8);
        @(posedge pclk);
        #1;
        chk("irq clear", 32'h0, irq);
        test_done;
    end
endmodule
